// >>> logic/alert_tracker.v
`timescale 1ns/10ps
// Input change detector with delayed active-high alert flag
module alert_tracker (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_n_in,
  // Current adjusted inputs and capture strobe
  input  wire [7:0] pin_value_in,
  input  wire [7:0] input_mask_in,
  input  wire       capture_in,
  // Alert
  output wire       alert_active_out
);
`include "io_expander_consts.vh"

  reg [7:0]  snap_q;
  reg [11:0] delay_q;
  reg        alert_q;
  wire       differ;

  // Output pins masked off so they never alert; a direction flip may alert
  assign differ = |((pin_value_in ^ snap_q) & input_mask_in);

  // Snapshot taken on input read; difference vanishes when pins return
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      snap_q <= 8'h00;
    end else if (capture_in) begin
      snap_q <= pin_value_in;
    end
  end

  // Alert only after difference stood for the valid delay
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      delay_q <= 12'h000;
      alert_q <= 1'b0;
    end else if (!differ || capture_in) begin
      delay_q <= 12'h000;
      alert_q <= 1'b0;
    end else if (delay_q == `ALERT_DELAY_CYC - 1) begin
      alert_q <= 1'b1;
    end else begin
      delay_q <= delay_q + 12'h001;
    end
  end

  assign alert_active_out = alert_q;
endmodule

// >>> logic/io_expander.v
`timescale 1ns/10ps
// Eight-bit two-wire I/O expander
module io_expander (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_n_in,
  // Device reset pin and power-on reset
  input  wire       ext_reset_n_in,
  input  wire       por_n_in,
  // Address straps
  input  wire       addr_select_bit0_in,
  input  wire       addr_select_bit1_in,
  // Two-wire bus
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_out,
  // Port pins
  input  wire [7:0] port_pins_in,
  output wire [7:0] port_pins_out,
  output wire [7:0] port_pins_oe_out,
  output wire [7:0] high_side_driver_out,
  output wire [7:0] low_side_driver_out,
  // Alert, open drain
  output wire       alert_n_out,
  output wire       alert_n_oe_out
);
`include "io_expander_consts.vh"

  //--------------------------------------------------
  // Reset combining and synchronising
  //--------------------------------------------------
  reg  [1:0] rst_sync_q;
  reg  [1:0] por_sync_q;
  reg  [1:0] a0_sync_q;
  reg  [1:0] a1_sync_q;
  wire       soft_rst_n;

  // Pin and power-on resets each pass two flops; no gate ahead of the first
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'b00;
      por_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], ext_reset_n_in};
      por_sync_q <= {por_sync_q[0], por_n_in};
    end
  end
  assign soft_rst_n = rst_n_in & rst_sync_q[1] & por_sync_q[1];

  // Address straps synchronised
  always @(posedge clk_in) begin
    if (!soft_rst_n) begin
      a0_sync_q <= 2'b00;
      a1_sync_q <= 2'b00;
    end else begin
      a0_sync_q <= {a0_sync_q[0], addr_select_bit0_in};
      a1_sync_q <= {a1_sync_q[0], addr_select_bit1_in};
    end
  end

  //--------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------
  reg  [7:0] pin_meta_q;
  reg  [7:0] pin_sync_q;
  reg  [7:0] output_q;
  reg  [7:0] polarity_q;
  reg  [7:0] config_q;
  wire [7:0] pin_value;

  always @(posedge clk_in) begin
    if (!soft_rst_n) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= port_pins_in;
      pin_sync_q <= pin_meta_q;
    end
  end
  // Every pin reported, inversion applied
  assign pin_value = pin_sync_q ^ polarity_q;

  //--------------------------------------------------
  // Bus line filtering and condition decode
  //--------------------------------------------------
  wire scl_f;
  wire sda_f;
  reg  scl_d1_q;
  reg  sda_d1_q;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;

  line_filter u_scl_filter (
    .clk_in    (clk_in),
    .rst_n_in  (soft_rst_n),
    .line_in   (scl_in),
    .level_out (scl_f)
  );
  line_filter u_sda_filter (
    .clk_in    (clk_in),
    .rst_n_in  (soft_rst_n),
    .line_in   (sda_in),
    .level_out (sda_f)
  );

  always @(posedge clk_in) begin
    if (!soft_rst_n) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_f;
      sda_d1_q <= sda_f;
    end
  end
  assign scl_rise   = scl_f & ~scl_d1_q;
  assign scl_fall   = ~scl_f & scl_d1_q;
  // SDA moving while SCL high is a bus condition, not data
  assign start_cond = scl_f & scl_d1_q & sda_d1_q & ~sda_f;
  assign stop_cond  = scl_f & scl_d1_q & ~sda_d1_q & sda_f;

  //--------------------------------------------------
  // Slave state machine
  //--------------------------------------------------
  localparam ST_IDLE  = 6'b000001;
  localparam ST_ADDR  = 6'b000010;
  localparam ST_WACK  = 6'b000100;
  localparam ST_WRITE = 6'b001000;
  localparam ST_READ  = 6'b010000;
  localparam ST_RACK  = 6'b100000;

  reg [5:0] state_q;
  reg [7:0] shift_q;
  reg [3:0] bit_cnt_q;
  reg       is_read_q;
  reg       got_ptr_q;
  reg       ack_pend_q;
  reg       sda_drv_q;
  wire [7:0] read_byte;
  reg [7:0] pointer_q;
  reg       read_clear;

  // Register read mux, used for load and reload
  function [7:0] reg_read;
    input [1:0] sel;
    input [7:0] pv;
    input [7:0] o;
    input [7:0] p;
    input [7:0] c;
    begin
      case (sel)
        `REG_INPUT:    reg_read = pv;
        `REG_OUTPUT:   reg_read = o;
        `REG_POLARITY: reg_read = p;
        default:       reg_read = c;
      endcase
    end
  endfunction

  // Address match: fixed upper bits then strap pins
  function addr_match;
    input [6:0] a;
    input       s1;
    input       s0;
    begin
      addr_match = (a == {`ADDR_FIXED_BITS, s1, s0});
    end
  endfunction

  // Byte to send, taken from the register the pointer selects
  assign read_byte = reg_read(pointer_q[1:0], pin_value, output_q, polarity_q, config_q);

  always @(posedge clk_in) begin
    read_clear <= 1'b0;
    if (!soft_rst_n) begin
      state_q    <= ST_IDLE;
      shift_q    <= 8'h00;
      bit_cnt_q  <= 4'h0;
      is_read_q  <= 1'b0;
      got_ptr_q  <= 1'b0;
      ack_pend_q <= 1'b0;
      sda_drv_q  <= 1'b0;
      pointer_q  <= `RST_POINTER;
      output_q   <= `RST_OUTPUT;
      polarity_q <= `RST_POLARITY;
      config_q   <= `RST_CONFIG;
      read_clear <= 1'b0;
    end else if (start_cond) begin
      state_q   <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      got_ptr_q <= 1'b0;
      sda_drv_q <= 1'b0;
    end else if (stop_cond) begin
      state_q   <= ST_IDLE;
      sda_drv_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sda_drv_q <= 1'b0;
        end
        ST_ADDR, ST_WRITE: begin
          // Sample on rise, MSB first
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (scl_fall && bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            if (state_q == ST_ADDR) begin
              if (addr_match(shift_q[7:1], a1_sync_q[1], a0_sync_q[1])) begin
                is_read_q <= shift_q[0];
                sda_drv_q <= 1'b1;
                state_q   <= ST_WACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              if (!got_ptr_q) begin
                pointer_q <= shift_q;
                got_ptr_q <= 1'b1;
              end else begin
                case (pointer_q[1:0])
                  `REG_OUTPUT:   output_q   <= shift_q;
                  `REG_POLARITY: polarity_q <= shift_q;
                  `REG_CONFIG:   config_q   <= shift_q;
                  default:       output_q   <= output_q;
                endcase
              end
              sda_drv_q <= 1'b1;
              state_q   <= ST_WACK;
            end
          end
        end
        ST_WACK: begin
          // Ack held low through the whole high phase
          if (scl_fall) begin
            if (is_read_q) begin
              shift_q   <= read_byte;
              sda_drv_q <= ~read_byte[7];
              bit_cnt_q <= 4'h1;
              state_q   <= ST_READ;
            end else begin
              sda_drv_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q   <= ST_WRITE;
            end
          end
        end
        ST_READ: begin
          // Only pull low for zero bits; ones are released
          if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              sda_drv_q <= 1'b0;
              state_q   <= ST_RACK;
            end else begin
              sda_drv_q <= ~shift_q[7 - bit_cnt_q[2:0]];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            ack_pend_q <= ~sda_f;
            if (pointer_q[1:0] == `REG_INPUT) begin
              read_clear <= 1'b1;
            end
          end
          if (scl_fall) begin
            if (ack_pend_q) begin
              shift_q   <= read_byte;
              sda_drv_q <= ~read_byte[7];
              bit_cnt_q <= 4'h1;
              state_q   <= ST_READ;
            end else begin
              sda_drv_q <= 1'b0;
              state_q   <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // SDA open drain: only drives low
  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_drv_q;

  //--------------------------------------------------
  // Port drivers
  //--------------------------------------------------
  assign high_side_driver_out = ~config_q & output_q;
  assign low_side_driver_out  = ~config_q & ~output_q;
  assign port_pins_out        = output_q;
  assign port_pins_oe_out     = ~config_q;

  //--------------------------------------------------
  // Alert
  //--------------------------------------------------
  wire alert_active;

  alert_tracker u_alert (
    .clk_in           (clk_in),
    .rst_n_in         (soft_rst_n),
    .pin_value_in     (pin_value),
    .input_mask_in    (config_q),
    .capture_in       (read_clear),
    .alert_active_out (alert_active)
  );

  // Pulls low only; pull-up gives the idle level
  assign alert_n_out    = 1'b0;
  assign alert_n_oe_out = alert_active;
endmodule

// >>> logic/io_expander_consts.vh
// Notes on behaviour
// - While reset is low, all registers and the bus state machine return to defaults.
// - After reset goes high, normal operation resumes for pins and bus.
// - Power-on reset holds the part in reset, then initialises everything to defaults.
// - Input pins have both high-side and low-side drivers switched off.
// - Output pins drive high or low per the output register bit.
// - Any edge on an input pin raises the alert after the alert valid delay.
// - Alert clears when pins return to captured value or input register is read.
// - Read clear happens at the acknowledge bit after SCL rises; changes then may vanish.
// - After clearing, every later input change raises the alert again.
// - Traffic for other devices and output pins never affect the alert.
// - Switching a pin from output to input may raise a tolerated alert.
// - Alert output is open-drain active low, pulling low only.
// - Device acknowledges its own address by holding SDA low through the ack pulse.
// - SDA stable while SCL high for data; SDA change during SCL high is START/STOP.
// - Any number of bytes per transfer, each eight bits plus one acknowledge.
// - Transmitter releases SDA before ack; acknowledger holds SDA low during ack high.
// - On master not-acknowledge the device releases SDA so the master can STOP.
// - Byte after write address is the pointer; two low bits pick the register.
// - Address is 11100 plus two select pins; last bit high means read.
// - Input register shows all pin levels with inversion applied; writes ignored.
// - Configuration bit one means input, zero output; resets to all ones.
`ifndef IO_EXPANDER_CONSTS_VH
`define IO_EXPANDER_CONSTS_VH

// Slave address upper bits
`define ADDR_FIXED_BITS    5'h1C
// Register pointer codes
`define REG_INPUT          2'h0
`define REG_OUTPUT         2'h1
`define REG_POLARITY       2'h2
`define REG_CONFIG         2'h3
// Reset values
`define RST_OUTPUT         8'hFF
`define RST_POLARITY       8'h00
`define RST_CONFIG         8'hFF
`define RST_POINTER        8'h00
// Timing
`define CLK_PERIOD_NS      10
`define ALERT_DELAY_NS     4000
`define ALERT_DELAY_CYC    (`ALERT_DELAY_NS / `CLK_PERIOD_NS)
`define GLITCH_FILTER_CYC  4'h5

`endif

// >>> logic/line_filter.v
`timescale 1ns/10ps
// Two-flop synchroniser plus stable-count glitch filter
module line_filter (
  // Clock and reset
  input  wire clk_in,
  input  wire rst_n_in,
  // Raw line and clean level
  input  wire line_in,
  output wire level_out
);
`include "io_expander_consts.vh"

  reg       meta_q;
  reg       sync_q;
  reg       level_q;
  reg [3:0] count_q;

  // Synchroniser; first flop read only by second
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= line_in;
      sync_q <= meta_q;
    end
  end

  // Accept a new level only after it stays stable, rejecting spikes
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      level_q <= 1'b1;
      count_q <= 4'h0;
    end else if (sync_q == level_q) begin
      count_q <= 4'h0;
    end else if (count_q == `GLITCH_FILTER_CYC) begin
      level_q <= sync_q;
      count_q <= 4'h0;
    end else begin
      count_q <= count_q + 4'h1;
    end
  end

  assign level_out = level_q;
endmodule

// >>> sim/i2c_master_model.sv
`timescale 1ns/10ps
// ----
// Two-wire bus master
// ----
module i2c_master_model #(
  parameter STEP_NS = 125
) (
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_pull_out
);
  // Idle: clock parked high, data released to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // Start or repeated start
  task start_cond;
    begin
      sda_pull_out = 1'b0;
      #(STEP_NS) scl_out = 1'b1;
      #(STEP_NS) sda_pull_out = 1'b1;
      #(STEP_NS) scl_out = 1'b0;
    end
  endtask
  // Stop closes a transfer unless a repeated start follows
  task stop_cond;
    begin
      sda_pull_out = 1'b1;
      #(STEP_NS) scl_out = 1'b1;
      #(STEP_NS) sda_pull_out = 1'b0;
      #(STEP_NS);
    end
  endtask
  // Data set mid-low, held through high, sampled mid-high
  task bit_xfer(input d, output q);
    begin
      #(STEP_NS) sda_pull_out = ~d;
      #(STEP_NS) scl_out = 1'b1;
      #(STEP_NS) q = sda_in;
      #(STEP_NS) scl_out = 1'b0;
    end
  endtask
  // MSB first, line released for the ack
  task send_byte(input [7:0] b, output ack);
    integer i;
    reg     q;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_xfer(b[i], q);
      bit_xfer(1'b1, ack);
    end
  endtask
  // Ack all but the last byte
  task recv_byte(input more, output [7:0] b);
    integer i;
    reg     q;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_xfer(1'b1, q);
        b[i] = q;
      end
      bit_xfer(~more, q);
    end
  endtask
endmodule

// >>> sim/io_expander_asserts.sv
`timescale 1ns/10ps
// ----
// Port checker
// ----
module io_expander_asserts (
  // Clock and resets
  input wire       clk_in,
  input wire       rst_n_in,
  input wire       ext_reset_n_in,
  input wire       por_n_in,
  // Bus and pins
  input wire       scl_in,
  input wire       sda_out,
  input wire       sda_oe_out,
  input wire [7:0] port_pins_out,
  input wire [7:0] port_pins_oe_out,
  input wire [7:0] high_side_driver_out,
  input wire [7:0] low_side_driver_out,
  input wire       alert_n_out,
  input wire       alert_n_oe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Open-drain lines may only pull low
  open_drain_a: assert property (alert_n_out == 1'b0 && sda_out == 1'b0)
    else $error("open-drain output drives high");
  // Never both drivers on one pin
  no_shoot_a: assert property ((high_side_driver_out & low_side_driver_out) == 8'h00)
    else $error("both drivers on");
  // Input pins keep both drivers off
  input_hiz_a: assert property
    (((high_side_driver_out | low_side_driver_out) & ~port_pins_oe_out) == 8'h00)
    else $error("input pin driven");
  // Reset pin, synced, returns defaults within four edges
  pin_reset_a: assert property (!ext_reset_n_in [*4] |=> port_pins_oe_out == 8'h00
    && port_pins_out == 8'hFF && !alert_n_oe_out) else $error("pin reset lost");
  por_reset_a: assert property (!por_n_in [*4] |=> !sda_oe_out && port_pins_oe_out == 8'h00)
    else $error("power-on reset lost");
  // Slave data moves only while the clock is low
  sda_hold_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("sda changed with scl high");
  ack_stable_a: assert property ($rose(scl_in) |=> $stable(sda_oe_out) [*4])
    else $error("sda not stable in high phase");
  // All-output ports have nothing to report
  alert_cause_a: assert property ($rose(alert_n_oe_out) |-> port_pins_oe_out != 8'hFF)
    else $error("alert with no input pin");
  cover property ($rose(alert_n_oe_out));
  cover property ($rose(sda_oe_out));
  cover property ($fell(por_n_in));
endmodule
bind io_expander io_expander_asserts chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .ext_reset_n_in(ext_reset_n_in), .por_n_in(por_n_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .port_pins_out(port_pins_out), .port_pins_oe_out(port_pins_oe_out),
  .high_side_driver_out(high_side_driver_out), .low_side_driver_out(low_side_driver_out),
  .alert_n_out(alert_n_out), .alert_n_oe_out(alert_n_oe_out));

// >>> sim/io_expander_bench.sv
`timescale 1ns/10ps
`include "io_expander_consts.vh"
module io_expander_bench;
  localparam [31:0] dflt = 32'hFF00FF00;
  reg        clk_in;
  reg        rst_n_in;
  reg        ext_reset_n_in;
  reg        por_n_in;
  reg  [1:0] sel;
  reg  [7:0] port_pins_in;
  reg  [7:0] rd;
  reg        ack;
  integer    err_total;
  integer    compares;
  integer    k;
  wire       scl, sda_pull, sda_out, sda_oe_out, alert_n_out, alert_n_oe_out;
  wire [7:0] port_pins_out, port_pins_oe_out, high_side_driver_out, low_side_driver_out;
  // Pulled-up lines: low whenever any party pulls
  wire       sda = ~(sda_pull | (sda_oe_out & ~sda_out));
  wire       alert_n = ~(alert_n_oe_out & ~alert_n_out);
  io_expander uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ext_reset_n_in(ext_reset_n_in),
    .por_n_in(por_n_in), .addr_select_bit0_in(sel[0]), .addr_select_bit1_in(sel[1]),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .port_pins_in(port_pins_in), .port_pins_out(port_pins_out),
    .port_pins_oe_out(port_pins_oe_out), .high_side_driver_out(high_side_driver_out),
    .low_side_driver_out(low_side_driver_out), .alert_n_out(alert_n_out),
    .alert_n_oe_out(alert_n_oe_out));
  i2c_master_model #(.STEP_NS(125)) mst (.sda_in(sda), .scl_out(scl), .sda_pull_out(sda_pull));
  // ----
  // Helpers
  // ----
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task check8(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task check1(input got, input exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask
  // Inputs move 1 ns after an edge, clear of sampling
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask
  function [7:0] dev_addr(input [1:0] s, input rw);
    dev_addr = {`ADDR_FIXED_BITS, s, rw};
  endfunction
  task reg_write(input [1:0] p, input [7:0] d);
    begin
      mst.start_cond;
      mst.send_byte(dev_addr(sel, 1'b0), ack);
      check1(ack, 1'b0);
      mst.send_byte({6'h00, p}, ack);
      mst.send_byte(d, ack);
      mst.stop_cond;
    end
  endtask
  // Pointer write is optional: an old pointer stays in force
  task reg_read(input setp, input [1:0] p, output [7:0] d);
    begin
      if (setp) begin
        mst.start_cond;
        mst.send_byte(dev_addr(sel, 1'b0), ack);
        mst.send_byte({6'h00, p}, ack);
      end
      mst.start_cond;
      mst.send_byte(dev_addr(sel, 1'b1), ack);
      check1(ack, 1'b0);
      mst.recv_byte(1'b0, d);
      mst.stop_cond;
    end
  endtask
  task probe(input [7:0] a, input exp);
    begin
      mst.start_cond;
      mst.send_byte(a, ack);
      mst.stop_cond;
      check1(ack, exp);
    end
  endtask
  task summarize;
    begin
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Run needs about 0.4 ms; twice that means a hang
  initial begin
    #800000;
    err_total = err_total + 1;
    $display("MISMATCH %0t watchdog expired", $time);
    summarize;
  end
  // ----
  // Tests
  // ----
  initial begin
    err_total = 0;
    compares = 0;
    rst_n_in = 1'b0;
    ext_reset_n_in = 1'b1;
    por_n_in = 1'b1;
    sel = 2'h0;
    port_pins_in = 8'h00;
    cyc(4);
    rst_n_in = 1'b1;
    cyc(12);
    check8(port_pins_oe_out, 8'h00);
    check8(high_side_driver_out | low_side_driver_out, 8'h00);
    for (k = 0; k < 4; k = k + 1) begin
      reg_read(1'b1, k[1:0], rd);
      check8(rd, dflt[k*8 +: 8]);
    end
    $display("test defaults done");
    reg_write(`REG_CONFIG, 8'h0F);
    reg_write(`REG_OUTPUT, 8'hA5);
    cyc(4);
    check8(port_pins_oe_out, 8'hF0);
    check8(high_side_driver_out, 8'hA0);
    check8(low_side_driver_out, 8'h50);
    check8(port_pins_out, 8'hA5);
    reg_read(1'b1, `REG_OUTPUT, rd);
    check8(rd, 8'hA5);
    cyc(1);
    port_pins_in = 8'h3C;
    reg_write(`REG_POLARITY, 8'h01);
    reg_write(`REG_INPUT, 8'hFF);
    reg_read(1'b0, 2'h0, rd);
    check8(rd, 8'h3D);
    $display("test port done");
    cyc(20);
    check1(alert_n, 1'b1);
    port_pins_in = 8'h3E;
    cyc(300);
    check1(alert_n, 1'b1);
    cyc(130);
    check1(alert_n, 1'b0);
    port_pins_in = 8'h3C;
    cyc(20);
    check1(alert_n, 1'b1);
    port_pins_in = 8'h3E;
    cyc(430);
    check1(alert_n, 1'b0);
    probe(dev_addr(2'h3, 1'b0), 1'b1);
    check1(alert_n, 1'b0);
    reg_read(1'b0, 2'h0, rd);
    check8(rd, 8'h3F);
    cyc(20);
    check1(alert_n, 1'b1);
    // Pointer moved off the input register once inputs are read
    reg_write(`REG_CONFIG, 8'h0F);
    cyc(1);
    port_pins_in = 8'hBE;
    cyc(430);
    check1(alert_n, 1'b1);
    $display("test alert done");
    for (k = 0; k < 4; k = k + 1) begin
      sel = k[1:0]; // straps move only between transfers
      cyc(4);
      probe(dev_addr(k[1:0], 1'b0), 1'b0);
      probe(dev_addr(~k[1:0], 1'b0), 1'b1);
    end
    sel = 2'h0;
    cyc(4);
    $display("test address done");
    for (k = 0; k < 2; k = k + 1) begin
      reg_write(`REG_CONFIG, 8'h00);
      cyc(1);
      if (k == 0)
        ext_reset_n_in = 1'b0;
      else
        por_n_in = 1'b0;
      cyc(5); // reset held well past the minimum pulse
      check8(port_pins_oe_out, 8'h00);
      ext_reset_n_in = 1'b1;
      por_n_in = 1'b1;
      cyc(12);
      reg_read(1'b1, `REG_CONFIG, rd);
      check8(rd, 8'hFF);
      reg_read(1'b1, `REG_OUTPUT, rd);
      check8(rd, 8'hFF);
    end
    $display("test reset done");
    summarize;
  end
endmodule
